// ===== core/aftl_pkg.sv
// Package of constants and types for the address filter table loader
package aftl_pkg;
  // ----------------------------------------------------------------------
  // Register offsets (register address pins)
  // ----------------------------------------------------------------------
  localparam logic [5:0] REG_COMMAND_CONTROL = 6'h00;
  localparam logic [5:0] REG_INTERRUPT_FLAGS = 6'h05;
  localparam logic [5:0] REG_UPPER_RESOURCE_BASE = 6'h14;
  localparam logic [5:0] REG_FILTER_ENTRY_INDEX = 6'h21;
  localparam logic [5:0] REG_FILTER_PORT_HIGH = 6'h22;
  localparam logic [5:0] REG_FILTER_PORT_MID = 6'h23;
  localparam logic [5:0] REG_FILTER_PORT_LOW = 6'h24;
  localparam logic [5:0] REG_FILTER_ENTRY_MASK = 6'h25;
  localparam logic [5:0] REG_FILTER_DESCRIPTOR_POINTER = 6'h26;
  localparam logic [5:0] REG_FILTER_DESCRIPTOR_COUNT = 6'h27;
  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CMD_LOAD_FILTER_BIT = 9;
  localparam int CMD_SOFT_RESET_BIT = 7;
  localparam int IRQ_LOAD_DONE_BIT = 3;
  localparam logic [15:0] CMD_RESET = 16'h0080;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam int COUNT_WIDTH = 5;
  localparam int INDEX_WIDTH = 4;
  localparam int ENTRIES = 16;
  localparam int CELLS = 3;
  localparam int FIELDS_PER_DESC = 4;
  localparam logic [15:0] FIELD_STEP = 16'h0001;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 5'h01;
  localparam logic [1:0] FIELD_LAST = 2'h3;
  localparam logic [1:0] FIELD_FIRST = 2'h0;
  localparam logic [1:0] CELL_HIGH = 2'h2;
  localparam logic [1:0] CELL_MID = 2'h1;
  localparam logic [1:0] CELL_LOW = 2'h0;
  // ----------------------------------------------------------------------
  // Loader states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_QUIET,
    ST_FETCH_DESC,
    ST_FETCH_MASK,
    ST_DONE
  } aftl_state_e;
endpackage : aftl_pkg

// ===== core/aftl_tbl_if.sv
// Interface carrying table write and read signals between loader and table
`timescale 1ns/1ps
interface aftl_tbl_if;
  logic wr_en;
  logic [3:0] wr_index;
  logic [1:0] wr_cell;
  logic [15:0] wr_data;
  logic [3:0] rd_index;
  logic [47:0] rd_entry;
  modport loader (output wr_en, output wr_index, output wr_cell, output wr_data,
    output rd_index, input rd_entry);
  modport table_side (input wr_en, input wr_index, input wr_cell, input wr_data,
    input rd_index, output rd_entry);
endinterface : aftl_tbl_if

// ===== core/aftl_table.sv
// Sixteen-entry 48-bit filter table built from 16-bit cells
`timescale 1ns/1ps
module aftl_table (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Table port
  aftl_tbl_if.table_side tbl
);
  logic [15:0] cells [aftl_pkg::ENTRIES][aftl_pkg::CELLS];
  logic [15:0] next_cells [aftl_pkg::ENTRIES][aftl_pkg::CELLS];

  always_comb begin
    next_cells = cells;
    if (tbl.wr_en) begin
      next_cells[tbl.wr_index][tbl.wr_cell] = tbl.wr_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int e = 0; e < aftl_pkg::ENTRIES; e++) begin
        for (int c = 0; c < aftl_pkg::CELLS; c++) begin
          cells[e][c] <= aftl_pkg::ZERO16;
        end
      end
    end else begin
      cells <= next_cells;
    end
  end

  // Cell 0 holds the least significant address bits
  assign tbl.rd_entry = {cells[tbl.rd_index][aftl_pkg::CELL_HIGH],
    cells[tbl.rd_index][aftl_pkg::CELL_MID], cells[tbl.rd_index][aftl_pkg::CELL_LOW]};
endmodule : aftl_table

// ===== core/aftl_loader.sv
// Filter table loader: register file, descriptor DMA and table ports
// Operation
// - Table written only by load; readable in reset
// - Descriptors contiguous, four packed 16-bit fields
// - 32-bit bus: upper data half ignored
// - Field 0 index, fields 1-3 cells
// - One extra field loads entry mask
// - Address is upper base plus pointer
// - Only low five count bits used
// - Load waits for transmit/receive to finish
// - Pointer past mask, count zero at end
// - Clear command bit, set done flag
// - Ports high 22, mid 23, low 24
// - Sixteen 48-bit entries, cell 0 least significant
`timescale 1ns/1ps
module aftl_loader (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Register access
  input wire logic i_reg_cs,
  input wire logic i_reg_wr,
  input wire logic [5:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  // Memory read bus
  output logic o_mem_req,
  output logic [31:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  // Link activity
  input wire logic i_tx_busy,
  input wire logic i_rx_busy,
  // Status
  output logic [15:0] o_filter_entry_mask,
  output logic o_load_busy
);
  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  aftl_pkg::aftl_state_e state, next_state;
  logic [15:0] command_control, next_command_control;
  logic [15:0] interrupt_flags, next_interrupt_flags;
  logic [15:0] upper_resource_base, next_upper_resource_base;
  logic [15:0] filter_entry_index, next_filter_entry_index;
  logic [15:0] filter_entry_mask, next_filter_entry_mask;
  logic [15:0] filter_descriptor_pointer, next_filter_descriptor_pointer;
  logic [15:0] filter_descriptor_count, next_filter_descriptor_count;
  logic [1:0] field, next_field;
  logic [3:0] load_index, next_load_index;
  logic mem_req, next_mem_req;
  logic [15:0] rdata, next_rdata;
  logic [15:0] fetched;
  logic wr_strobe;
  logic in_soft_reset;

  aftl_tbl_if tbl ();

  aftl_table u_table (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .tbl(tbl)
  );

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [5:0] addr, input logic [5:0] reg_off);
    hit = (addr == reg_off);
  endfunction : hit

  assign wr_strobe = i_reg_cs && i_reg_wr;
  assign in_soft_reset = command_control[aftl_pkg::CMD_SOFT_RESET_BIT];
  assign fetched = i_mem_rdata[15:0];

  // ----------------------------------------------------------------------
  // Table port
  // ----------------------------------------------------------------------
  assign tbl.rd_index = filter_entry_index[aftl_pkg::INDEX_WIDTH-1:0];
  always_comb begin
    tbl.wr_en = 1'b0;
    tbl.wr_index = load_index;
    tbl.wr_cell = aftl_pkg::CELL_LOW;
    tbl.wr_data = fetched;
    if (state == aftl_pkg::ST_FETCH_DESC && mem_req && i_mem_ack &&
        field != aftl_pkg::FIELD_FIRST) begin
      tbl.wr_en = 1'b1;
      tbl.wr_cell = aftl_pkg::FIELD_LAST - field;
    end
  end

  // ----------------------------------------------------------------------
  // Loader and register file
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_command_control = command_control;
    next_interrupt_flags = interrupt_flags;
    next_upper_resource_base = upper_resource_base;
    next_filter_entry_index = filter_entry_index;
    next_filter_entry_mask = filter_entry_mask;
    next_filter_descriptor_pointer = filter_descriptor_pointer;
    next_filter_descriptor_count = filter_descriptor_count;
    next_field = field;
    next_load_index = load_index;
    next_mem_req = mem_req;

    if (wr_strobe) begin
      if (hit(i_reg_addr, aftl_pkg::REG_COMMAND_CONTROL)) begin
        next_command_control = i_reg_wdata;
      end
      if (hit(i_reg_addr, aftl_pkg::REG_INTERRUPT_FLAGS)) begin
        next_interrupt_flags = interrupt_flags & ~i_reg_wdata;
      end
      if (hit(i_reg_addr, aftl_pkg::REG_UPPER_RESOURCE_BASE)) begin
        next_upper_resource_base = i_reg_wdata;
      end
      if (hit(i_reg_addr, aftl_pkg::REG_FILTER_ENTRY_INDEX)) begin
        next_filter_entry_index = i_reg_wdata;
      end
      if (hit(i_reg_addr, aftl_pkg::REG_FILTER_ENTRY_MASK)) begin
        next_filter_entry_mask = i_reg_wdata;
      end
      if (hit(i_reg_addr, aftl_pkg::REG_FILTER_DESCRIPTOR_POINTER)) begin
        next_filter_descriptor_pointer = i_reg_wdata;
      end
      if (hit(i_reg_addr, aftl_pkg::REG_FILTER_DESCRIPTOR_COUNT)) begin
        next_filter_descriptor_count = i_reg_wdata;
      end
    end

    unique case (state)
      aftl_pkg::ST_IDLE: begin
        if (command_control[aftl_pkg::CMD_LOAD_FILTER_BIT]) begin
          next_state = aftl_pkg::ST_WAIT_QUIET;
        end
      end
      aftl_pkg::ST_WAIT_QUIET: begin
        if (!i_tx_busy && !i_rx_busy) begin
          next_field = aftl_pkg::FIELD_FIRST;
          next_mem_req = 1'b1;
          if (filter_descriptor_count[aftl_pkg::COUNT_WIDTH-1:0] == '0) begin
            next_state = aftl_pkg::ST_FETCH_MASK;
          end else begin
            next_state = aftl_pkg::ST_FETCH_DESC;
          end
        end
      end
      aftl_pkg::ST_FETCH_DESC: begin
        if (i_mem_ack) begin
          next_filter_descriptor_pointer = filter_descriptor_pointer + aftl_pkg::FIELD_STEP;
          next_field = field + 2'h1;
          if (field == aftl_pkg::FIELD_FIRST) begin
            next_load_index = fetched[aftl_pkg::INDEX_WIDTH-1:0];
          end
          if (field == aftl_pkg::FIELD_LAST) begin
            next_filter_descriptor_count = {{(16 - aftl_pkg::COUNT_WIDTH){1'b0}},
              filter_descriptor_count[aftl_pkg::COUNT_WIDTH-1:0] - aftl_pkg::COUNT_ONE};
            if (filter_descriptor_count[aftl_pkg::COUNT_WIDTH-1:0] == aftl_pkg::COUNT_ONE) begin
              next_state = aftl_pkg::ST_FETCH_MASK;
            end
          end
        end
      end
      aftl_pkg::ST_FETCH_MASK: begin
        if (i_mem_ack) begin
          next_filter_entry_mask = fetched;
          next_filter_descriptor_pointer = filter_descriptor_pointer + aftl_pkg::FIELD_STEP;
          next_filter_descriptor_count = aftl_pkg::ZERO16;
          next_mem_req = 1'b0;
          next_state = aftl_pkg::ST_DONE;
        end
      end
      aftl_pkg::ST_DONE: begin
        next_command_control[aftl_pkg::CMD_LOAD_FILTER_BIT] = 1'b0;
        next_interrupt_flags[aftl_pkg::IRQ_LOAD_DONE_BIT] = 1'b1;
        next_state = aftl_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = aftl_pkg::ZERO16;
    if (i_reg_cs && !i_reg_wr) begin
      unique case (i_reg_addr)
        aftl_pkg::REG_COMMAND_CONTROL: next_rdata = command_control;
        aftl_pkg::REG_INTERRUPT_FLAGS: next_rdata = interrupt_flags;
        aftl_pkg::REG_UPPER_RESOURCE_BASE: next_rdata = upper_resource_base;
        aftl_pkg::REG_FILTER_ENTRY_INDEX: next_rdata = filter_entry_index;
        aftl_pkg::REG_FILTER_PORT_HIGH: next_rdata = in_soft_reset ? tbl.rd_entry[47:32] : aftl_pkg::ZERO16;
        aftl_pkg::REG_FILTER_PORT_MID: next_rdata = in_soft_reset ? tbl.rd_entry[31:16] : aftl_pkg::ZERO16;
        aftl_pkg::REG_FILTER_PORT_LOW: next_rdata = in_soft_reset ? tbl.rd_entry[15:0] : aftl_pkg::ZERO16;
        aftl_pkg::REG_FILTER_ENTRY_MASK: next_rdata = filter_entry_mask;
        aftl_pkg::REG_FILTER_DESCRIPTOR_POINTER: next_rdata = filter_descriptor_pointer;
        aftl_pkg::REG_FILTER_DESCRIPTOR_COUNT: next_rdata = filter_descriptor_count;
        default: next_rdata = aftl_pkg::ZERO16;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= aftl_pkg::ST_IDLE;
      command_control <= aftl_pkg::CMD_RESET;
      interrupt_flags <= aftl_pkg::ZERO16;
      upper_resource_base <= aftl_pkg::ZERO16;
      filter_entry_index <= aftl_pkg::ZERO16;
      filter_entry_mask <= aftl_pkg::ZERO16;
      filter_descriptor_pointer <= aftl_pkg::ZERO16;
      filter_descriptor_count <= aftl_pkg::ZERO16;
      field <= aftl_pkg::FIELD_FIRST;
      load_index <= '0;
      mem_req <= 1'b0;
      rdata <= aftl_pkg::ZERO16;
    end else begin
      state <= next_state;
      command_control <= next_command_control;
      interrupt_flags <= next_interrupt_flags;
      upper_resource_base <= next_upper_resource_base;
      filter_entry_index <= next_filter_entry_index;
      filter_entry_mask <= next_filter_entry_mask;
      filter_descriptor_pointer <= next_filter_descriptor_pointer;
      filter_descriptor_count <= next_filter_descriptor_count;
      field <= next_field;
      load_index <= next_load_index;
      mem_req <= next_mem_req;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic [31:0] mem_addr, next_mem_addr;
  logic load_busy, next_load_busy;

  // Address follows the pointer on the same edge a field is consumed
  always_comb begin
    next_mem_addr = {next_upper_resource_base, next_filter_descriptor_pointer};
    next_load_busy = (next_state != aftl_pkg::ST_IDLE);
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      mem_addr <= '0;
      load_busy <= 1'b0;
    end else begin
      mem_addr <= next_mem_addr;
      load_busy <= next_load_busy;
    end
  end

  assign o_reg_rdata = rdata;
  assign o_mem_req = mem_req;
  assign o_mem_addr = mem_addr;
  assign o_filter_entry_mask = filter_entry_mask;
  assign o_load_busy = load_busy;
endmodule : aftl_loader

// ===== bench/aftl_loader_monitor.sv
// Checker of the loader's register and memory port timing
`timescale 1ns/1ps
module aftl_loader_monitor (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Register access
  input wire logic i_reg_cs,
  input wire logic i_reg_wr,
  input wire logic [5:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  // Memory read bus
  input wire logic o_mem_req,
  input wire logic [31:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  // Link activity and status
  input wire logic i_tx_busy,
  input wire logic i_rx_busy,
  input wire logic [15:0] o_filter_entry_mask,
  input wire logic o_load_busy
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------------------------------------
  // Last field taken from memory
  // ----------------------------------------------------------------------
  logic [15:0] last_low;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      last_low <= 16'h0000;
    end else if (o_mem_req && i_mem_ack) begin
      last_low <= i_mem_rdata[15:0];
    end
  end
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_addr_step;
    o_mem_req && i_mem_ack |=> !o_mem_req || (o_mem_addr[15:0] == $past(o_mem_addr[15:0]) + 16'h0001);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("pointer step wrong");
  property p_req_hold;
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request not held");
  property p_upper_fixed;
    o_mem_req && $past(o_mem_req) |-> $stable(o_mem_addr[31:16]);
  endproperty
  a_upper_fixed: assert property (p_upper_fixed) else $error("upper address moved");
  property p_wait_quiet;
    $rose(o_mem_req) |-> $past(!i_tx_busy && !i_rx_busy);
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("fetch during traffic");
  property p_mask_load;
    $fell(o_mem_req) |-> ##[0:2] (o_filter_entry_mask == last_low);
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask not loaded");
  property p_req_in_load;
    o_mem_req |-> o_load_busy;
  endproperty
  a_req_in_load: assert property (p_req_in_load) else $error("request while idle");
  property p_end_load;
    $fell(o_mem_req) |-> ##[0:2] !o_load_busy;
  endproperty
  a_end_load: assert property (p_end_load) else $error("load did not end");
  property p_unmapped;
    i_reg_cs && !i_reg_wr && (i_reg_addr == 6'h3f) |=> o_reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : aftl_loader_monitor
bind aftl_loader aftl_loader_monitor u_mon (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
  .i_reg_cs(i_reg_cs), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_mem_req(o_mem_req),
  .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
  .i_tx_busy(i_tx_busy), .i_rx_busy(i_rx_busy),
  .o_filter_entry_mask(o_filter_entry_mask), .o_load_busy(o_load_busy));

// ===== bench/aftl_mem_model.sv
// System memory holding the descriptor area
`timescale 1ns/1ps
module aftl_mem_model #(
  parameter logic [15:0] UPPER = 16'h0012
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Memory read bus
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  output logic o_ack,
  output logic [31:0] o_rdata,
  // Answer three cycles late when high
  input wire logic i_slow
);
  logic [15:0] mem [0:4095];
  logic [1:0] wait_cnt;
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack <= 1'b0;
      wait_cnt <= 2'h0;
      o_rdata <= 32'h5a5a5a5a;
    end else if (i_req && !o_ack && (!i_slow || wait_cnt == 2'h3)) begin
      o_ack <= 1'b1;
      wait_cnt <= 2'h0;
      // Wrong page returns junk; upper half is junk on purpose
      o_rdata[15:0] <= (i_addr[31:16] == UPPER) ? mem[i_addr[11:0]] : 16'hdead;
      o_rdata[31:16] <= ~mem[i_addr[11:0]];
    end else begin
      o_ack <= 1'b0;
      wait_cnt <= i_req ? wait_cnt + 2'h1 : 2'h0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule : aftl_mem_model

// ===== bench/testbench.sv
// Register-level tests of the filter table loader
`timescale 1ns/1ps
module testbench;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_reg_cs = 1'b0;
  logic i_reg_wr = 1'b0;
  logic [5:0] i_reg_addr = 6'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic [15:0] o_reg_rdata;
  logic o_mem_req, i_mem_ack, o_load_busy;
  logic [31:0] o_mem_addr, i_mem_rdata;
  logic i_tx_busy = 1'b0;
  logic i_rx_busy = 1'b0;
  logic i_slow = 1'b0;
  logic [15:0] o_filter_entry_mask;
  int fails = 0;
  int n_tests = 0;
  logic [15:0] img [0:8] = '{16'h0003, 16'ha1a2, 16'hb1b2, 16'hc1c2,
    16'h000f, 16'hd1d2, 16'he1e2, 16'hf1f2, 16'h8008};
  always #2 i_clk_sys = ~i_clk_sys;
  aftl_loader u_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_cs(i_reg_cs),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
    .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .i_tx_busy(i_tx_busy),
    .i_rx_busy(i_rx_busy), .o_filter_entry_mask(o_filter_entry_mask),
    .o_load_busy(o_load_busy));
  aftl_mem_model #(.UPPER(16'h0012)) u_mem (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_req(o_mem_req), .i_addr(o_mem_addr), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata),
    .i_slow(i_slow));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    i_reg_cs = 1'b1;
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk_sys);
    i_reg_cs = 1'b0;
    i_reg_wr = 1'b0;
    // Idle cycle so a following access never re-raises the select in the same step
    @(negedge i_clk_sys);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] e, input string name);
    i_reg_cs = 1'b1;
    i_reg_addr = a;
    @(negedge i_clk_sys);
    i_reg_cs = 1'b0;
    chk(name, e, o_reg_rdata);
    @(negedge i_clk_sys);
  endtask : rd
  task automatic run_load(input logic [15:0] cmd);
    wr(aftl_pkg::REG_COMMAND_CONTROL, cmd);
    for (int i = 0; i < 300 && o_load_busy !== 1'b0; i++) @(negedge i_clk_sys);
    chk("load_busy", 16'h0000, {15'h0000, o_load_busy});
  endtask : run_load
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    #(40000 * 4);
    fails++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 9; i++) u_mem.mem[12'h100 + i] = img[i];
    u_mem.mem[12'h200] = 16'h1234;
    repeat (10) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    rd(aftl_pkg::REG_COMMAND_CONTROL, 16'h0080, "cmd_reset");
    rd(6'h3f, 16'h0000, "unmapped");
    wr(aftl_pkg::REG_UPPER_RESOURCE_BASE, 16'h0012);
    wr(aftl_pkg::REG_FILTER_DESCRIPTOR_COUNT, 16'hffe2);
    wr(aftl_pkg::REG_FILTER_DESCRIPTOR_POINTER, 16'h0100);
    i_tx_busy = 1'b1;
    wr(aftl_pkg::REG_COMMAND_CONTROL, 16'h0280);
    repeat (20) @(negedge i_clk_sys);
    chk("req_held_off", 16'h0000, {15'h0000, o_mem_req});
    chk("busy_waiting", 16'h0001, {15'h0000, o_load_busy});
    i_tx_busy = 1'b0;
    run_load(16'h0280);
    rd(aftl_pkg::REG_FILTER_DESCRIPTOR_POINTER, 16'h0109, "ptr_end");
    rd(aftl_pkg::REG_FILTER_DESCRIPTOR_COUNT, 16'h0000, "cnt_end");
    rd(aftl_pkg::REG_COMMAND_CONTROL, 16'h0080, "cmd_end");
    rd(aftl_pkg::REG_INTERRUPT_FLAGS, 16'h0008, "done_flag");
    rd(aftl_pkg::REG_FILTER_ENTRY_MASK, 16'h8008, "mask_reg");
    for (int e = 0; e < 2; e++) begin
      wr(aftl_pkg::REG_FILTER_ENTRY_INDEX, img[4 * e]);
      rd(aftl_pkg::REG_FILTER_PORT_HIGH, img[4 * e + 1], "port_high");
      rd(aftl_pkg::REG_FILTER_PORT_MID, img[4 * e + 2], "port_mid");
      rd(aftl_pkg::REG_FILTER_PORT_LOW, img[4 * e + 3], "port_low");
    end
    wr(aftl_pkg::REG_INTERRUPT_FLAGS, 16'h0008);
    rd(aftl_pkg::REG_INTERRUPT_FLAGS, 16'h0000, "flag_clear");
    wr(aftl_pkg::REG_COMMAND_CONTROL, 16'h0000);
    rd(aftl_pkg::REG_FILTER_PORT_LOW, 16'h0000, "port_hidden");
    wr(aftl_pkg::REG_FILTER_DESCRIPTOR_POINTER, 16'h0200);
    i_slow = 1'b1;
    i_rx_busy = 1'b1;
    wr(aftl_pkg::REG_COMMAND_CONTROL, 16'h0200);
    repeat (8) @(negedge i_clk_sys);
    chk("rx_held_off", 16'h0000, {15'h0000, o_mem_req});
    i_rx_busy = 1'b0;
    run_load(16'h0200);
    chk("mask_port", 16'h1234, o_filter_entry_mask);
    rd(aftl_pkg::REG_FILTER_DESCRIPTOR_POINTER, 16'h0201, "ptr_mask_only");
    wr(aftl_pkg::REG_COMMAND_CONTROL, 16'h0080);
    wr(aftl_pkg::REG_FILTER_ENTRY_INDEX, 16'h000f);
    rd(aftl_pkg::REG_FILTER_PORT_HIGH, 16'hd1d2, "table_kept");
    tally_and_finish();
  end
endmodule : testbench
